// ### hdl/rotate_pkg.sv
package rotate_pkg;

  // Top six opcode bits that select the rotate right without carry instruction.
  localparam logic [5:0]  ROT_OPCODE      = 6'h10;

  // Value of the destination bit that selects the working register.
  localparam logic        DEST_WORKING    = 1'h0;

  // Value of the access bit that selects the access bank.
  localparam logic        ACCESS_BANK_SEL = 1'h0;

  // Highest file address field that means an indexed literal offset.
  localparam logic [7:0]  INDEX_LIMIT     = 8'h5F;

  // First file address field that maps to the upper access bank half.
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;

  // Bank numbers that the two halves of the access bank map to.
  localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;

  // Reset values of the byte-wide state and of the address.
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam logic [11:0] ADDR_RESET      = 12'h000;

  // Width figures shared by the files.
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 12;

  // Quarter phases of one instruction cycle, plus the idle state between instructions.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_e;

  // Fields of one program word of this instruction.
  typedef struct packed {
    logic [5:0] opcode;     // Fixed opcode pattern.
    logic       dest;       // Destination select.
    logic       access;     // Access bank or bank select register.
    logic [7:0] file_addr;  // File address field.
  } instr_s;

  // Request to the data memory: one read and, for a file destination, one write per instruction.
  typedef struct packed {
    logic [11:0] addr;      // Resolved data address.
    logic        rd_en;     // Read strobe, high during the read phase.
    logic        wr_en;     // Write strobe, high during the write phase.
    logic [7:0]  wr_data;   // Data written back to the file register.
  } mem_req_s;

endpackage

// ### hdl/rotate_byte.sv
`timescale 1ns/10ps

// Rotates a byte right by one place with the low bit wrapping to the top, and gives the flags.
module rotate_byte (
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            neg_o,
  output logic            zero_o
);

  // The low bit re-enters at the top; no carry takes part.
  assign data_o = {data_i[0], data_i[7:1]};

  // Negative follows the new top bit, zero follows the whole result.
  assign neg_o  = data_o[7];
  assign zero_o = (data_o == 8'h00);

endmodule

// ### hdl/rotate_right_nocarry_exec.sv
`timescale 1ns/10ps

module rotate_right_nocarry_exec (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   instr_valid_i,
  input  wire rotate_pkg::instr_s     instr_i,
  input  wire logic                   ext_set_en_i,
  input  wire logic [3:0]             bank_select_reg_i,
  input  wire logic [11:0]            index_base_i,
  input  wire logic [7:0]             rd_data_i,
  output rotate_pkg::mem_req_s        mem_req_o,
  output logic      [7:0]             w_reg_o,
  output logic                        flag_n_o,
  output logic                        flag_z_o,
  output logic                        flag_we_o,
  output logic                        busy_o,
  output logic                        done_o
);
  import rotate_pkg::*;

  // Phase of the instruction cycle in progress.
  phase_e      phase_reg;
  phase_e      phase_next;

  // Program word captured when the instruction is taken.
  instr_s      instr_reg;

  // Operand byte read in the read phase, left untouched through the write phase.
  logic [7:0]  operand_reg;

  // Registered outputs.
  mem_req_s    mem_req_reg;
  logic [7:0]  w_reg;
  logic        flag_n_reg;
  logic        flag_z_reg;
  logic        flag_we_reg;
  logic        done_reg;

  // Decoded fields of the captured word.
  wire         take_w;          // A matching word is accepted this cycle.
  wire  [7:0]  f_w;             // File address field.
  wire         dest_file_w;     // Result goes back to the file register.
  wire         access_bank_w;   // Access bank addressing chosen.
  wire         indexed_w;       // Indexed literal offset addressing chosen.
  wire  [11:0] access_addr_w;   // Address inside the access bank.
  wire  [11:0] banked_addr_w;   // Address in the bank the bank register names.
  wire  [11:0] indexed_addr_w;  // Index base plus the literal offset.
  wire  [11:0] resolved_addr_w; // Address finally used.

  // Rotator outputs.
  wire  [7:0]  rot_data_w;
  wire         rot_neg_w;
  wire         rot_zero_w;

  // Only a word with the right opcode is taken, and only between instructions.
  assign take_w        = instr_valid_i && (phase_reg == PH_IDLE) && (instr_i.opcode == ROT_OPCODE);

  assign f_w           = instr_reg.file_addr;
  assign dest_file_w   = (instr_reg.dest != DEST_WORKING);
  assign access_bank_w = (instr_reg.access == ACCESS_BANK_SEL);

  // Low fields become an indexed offset only with the extended set on.
  assign indexed_w     = ext_set_en_i && access_bank_w && (f_w <= INDEX_LIMIT);

  // The access bank is split: low half in the first bank, high half in the last.
  assign access_addr_w = (f_w < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f_w}
                                              : {ACCESS_HIGH_BANK, f_w};

  // The bank register supplies the upper bits of a banked address.
  assign banked_addr_w = {bank_select_reg_i, f_w};

  // The offset is added to the index base; overflow wraps in the data space.
  assign indexed_addr_w = index_base_i + {4'h0, f_w};

  // Indexed mode overrides the plain access bank, which overrides the banked address.
  assign resolved_addr_w = indexed_w     ? indexed_addr_w :
                           access_bank_w ? access_addr_w  :
                                           banked_addr_w;

  // Rotation of the operand held from the read phase.
  rotate_byte u_rotate (
    .data_i (operand_reg),
    .data_o (rot_data_w),
    .neg_o  (rot_neg_w),
    .zero_o (rot_zero_w)
  );

  // Phase sequencing: one quarter phase per clock, back to idle after the write.
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_IDLE:    phase_next = take_w ? PH_DECODE : PH_IDLE;
      PH_DECODE:  phase_next = PH_READ;
      PH_READ:    phase_next = PH_PROCESS;
      PH_PROCESS: phase_next = PH_WRITE;
      PH_WRITE:   phase_next = PH_IDLE;
    endcase
  end

  // Phase register.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // The program word is held for the whole instruction.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      instr_reg <= '0;
    end else if (take_w) begin
      instr_reg <= instr_i;
    end
  end

  // Decode resolves the address and raises the read strobe; process sets up the write.
  // The whole request struct lives in this one process so that it has a single driver.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mem_req_reg.addr    <= ADDR_RESET;
      mem_req_reg.rd_en   <= 1'b0;
      mem_req_reg.wr_en   <= 1'b0;
      mem_req_reg.wr_data <= BYTE_RESET;
    end else begin
      if (phase_reg == PH_DECODE) begin
        mem_req_reg.addr <= resolved_addr_w;
      end
      mem_req_reg.rd_en <= (phase_reg == PH_DECODE);
      // Write strobe covers the write phase only, and only for a file destination.
      mem_req_reg.wr_en <= (phase_reg == PH_PROCESS) && dest_file_w;
      if (phase_reg == PH_PROCESS) begin
        mem_req_reg.wr_data <= rot_data_w;
      end
    end
  end

  // The operand is caught while the read strobe is high.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      operand_reg <= BYTE_RESET;
    end else if (phase_reg == PH_READ) begin
      operand_reg <= rd_data_i;
    end
  end

  // The working register takes the result when it is the destination.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_reg <= BYTE_RESET;
    end else if ((phase_reg == PH_PROCESS) && !dest_file_w) begin
      w_reg <= rot_data_w;
    end
  end

  // Only the negative and zero flags change, in the write phase.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_n_reg  <= 1'b0;
      flag_z_reg  <= 1'b0;
      flag_we_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      flag_we_reg <= (phase_reg == PH_PROCESS);
      done_reg    <= (phase_reg == PH_PROCESS);
      if (phase_reg == PH_PROCESS) begin
        flag_n_reg <= rot_neg_w;
        flag_z_reg <= rot_zero_w;
      end
    end
  end

  // Busy is registered from the next phase so it lines up with the phases.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (phase_next != PH_IDLE);
    end
  end

  // Output drivers, all straight from flip-flops.
  assign mem_req_o = mem_req_reg;
  assign w_reg_o   = w_reg;
  assign flag_n_o  = flag_n_reg;
  assign flag_z_o  = flag_z_reg;
  assign flag_we_o = flag_we_reg;
  assign done_o    = done_reg;

  // Checks run on the core clock and stand down in reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // The four quarter phases follow a taken word in order.
  sequence s_quarters;
    phase_reg == PH_DECODE ##1 phase_reg == PH_READ ##1 phase_reg == PH_PROCESS ##1 phase_reg == PH_WRITE;
  endsequence

  a_phase_order: assert property (take_w |=> s_quarters ##1 phase_reg == PH_IDLE)
    else $error("Quarter phases out of order.");

  a_read_in_q2: assert property ((phase_reg == PH_READ) == mem_req_o.rd_en)
    else $error("Read strobe not confined to the read phase.");

  // The byte read two cycles earlier, rotated, lands in the working register and no file write happens.
  a_rotate_to_w: assert property (
    (phase_reg == PH_READ && !dest_file_w) |-> ##2
      ((w_reg_o == {$past(rd_data_i[0], 2), $past(rd_data_i[7:1], 2)}) && !mem_req_o.wr_en))
    else $error("Working register result wrong or file written.");

  a_rotate_to_f: assert property (
    (phase_reg == PH_READ && dest_file_w) |-> ##2 (mem_req_o.wr_en
      && mem_req_o.wr_data == {$past(rd_data_i[0], 2), $past(rd_data_i[7:1], 2)}))
    else $error("File write missing or rotated value wrong.");

  // Flags are judged from the operand itself, not from the rotator that made them.
  a_flags_track: assert property (
    flag_we_o |-> (flag_z_o == (operand_reg == 8'h00)) && (flag_n_o == operand_reg[0]))
    else $error("Negative or zero flag does not match the result.");

  a_access_bank: assert property (
    (phase_reg == PH_DECODE && access_bank_w && !indexed_w)
    |=> mem_req_o.addr == {($past(f_w) < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, $past(f_w)})
    else $error("Access bank address wrong.");

  a_banked_addr: assert property (
    (phase_reg == PH_DECODE && !access_bank_w)
    |=> mem_req_o.addr == {$past(bank_select_reg_i), $past(f_w)})
    else $error("Banked address does not follow the bank register.");

  a_indexed_addr: assert property (
    (phase_reg == PH_DECODE && ext_set_en_i && access_bank_w && f_w <= INDEX_LIMIT)
    |=> mem_req_o.addr == $past(index_base_i) + {4'h0, $past(f_w)})
    else $error("Indexed literal offset address wrong.");

endmodule

// ### testbench/rotate_right_nocarry_exec_tb.sv
`timescale 1ns/10ps

// Self-checking bench for the rotate right without carry execution block.
module rotate_right_nocarry_exec_tb;
  import rotate_pkg::*;

  logic        clk_i;             // Core clock, 20 ns period.
  logic        rst_n_i;           // Synchronous reset, active low.
  logic        instr_valid_i;     // Program word valid.
  instr_s      instr_i;           // Program word.
  logic        ext_set_en_i;      // Extended instruction set switch.
  logic [3:0]  bank_select_reg_i; // Bank select register value.
  logic [11:0] index_base_i;      // Base for indexed literal offset.
  logic [7:0]  rd_data_i;         // Data returned by data memory.
  mem_req_s    mem_req_o;         // Data memory request.
  logic [7:0]  w_reg_o;           // Working register.
  logic        flag_n_o;          // Negative flag.
  logic        flag_z_o;          // Zero flag.
  logic        flag_we_o;         // Flag update pulse.
  logic        busy_o;            // Instruction in flight.
  logic        done_o;            // Write phase pulse.
  int          errors;            // Mismatches seen.
  int          check_count;       // Comparisons made.
  logic [7:0]  w_exp;             // Expected working register.

  rotate_right_nocarry_exec DUT (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .instr_valid_i     (instr_valid_i),
    .instr_i           (instr_i),
    .ext_set_en_i      (ext_set_en_i),
    .bank_select_reg_i (bank_select_reg_i),
    .index_base_i      (index_base_i),
    .rd_data_i         (rd_data_i),
    .mem_req_o         (mem_req_o),
    .w_reg_o           (w_reg_o),
    .flag_n_o          (flag_n_o),
    .flag_z_o          (flag_z_o),
    .flag_we_o         (flag_we_o),
    .busy_o            (busy_o),
    .done_o            (done_o)
  );

  // Free running clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Runs one instruction and follows it phase by phase.
  task automatic run_op(input logic d, input logic a, input logic [7:0] f, input logic ext,
                        input logic [3:0] bank, input logic [11:0] base, input logic [7:0] din,
                        input logic [11:0] exp_addr);
    logic [7:0] res;
    res = {din[0], din[7:1]};
    @(posedge clk_i);
    instr_valid_i     <= 1'b1;
    instr_i           <= {ROT_OPCODE, d, a, f};
    ext_set_en_i      <= ext;
    bank_select_reg_i <= bank;
    index_base_i      <= base;
    rd_data_i         <= din;
    // This edge takes the word; the decode phase follows it at once.
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1 chk(busy_o, 1'b1, "decode busy");
    @(posedge clk_i);
    #1 chk(mem_req_o.rd_en, 1'b1, "read strobe");
    chk(mem_req_o.addr, exp_addr, "operand address");
    @(posedge clk_i);
    #1 chk(mem_req_o.rd_en, 1'b0, "read strobe drop");
    chk(done_o, 1'b0, "early done");
    @(posedge clk_i);
    #1 chk(done_o, 1'b1, "write done");
    chk(flag_we_o, 1'b1, "flag update");
    chk(flag_n_o, res[7], "negative flag");
    chk(flag_z_o, (res == 8'h00), "zero flag");
    chk(mem_req_o.wr_en, d, "file write strobe");
    if (d == DEST_WORKING) begin
      w_exp = res;
    end else begin
      chk(mem_req_o.wr_data, res, "file write data");
    end
    chk(w_reg_o, w_exp, "working register");
    @(posedge clk_i);
    #1 chk({busy_o, done_o, flag_we_o, mem_req_o.wr_en}, 4'h0, "idle after write");
  endtask

  // Result into the working register, upper access bank half, bank register ignored.
  task automatic t_dest_working();
    run_op(1'b0, 1'b0, 8'h80, 1'b0, 4'h7, 12'h000, 8'hD7, {ACCESS_HIGH_BANK, 8'h80});
  endtask

  // Result back into the file register through the bank register.
  task automatic t_dest_file();
    run_op(1'b1, 1'b1, 8'h12, 1'b0, 4'h5, 12'h000, 8'h01, 12'h512);
    run_op(1'b1, 1'b1, 8'hFF, 1'b1, 4'hA, 12'h300, 8'h00, 12'hAFF);
  endtask

  // Indexed literal offset at and around the field boundary.
  task automatic t_indexed();
    run_op(1'b0, 1'b0, 8'h5F, 1'b1, 4'h3, 12'h100, 8'hAA, 12'h15F);
    run_op(1'b0, 1'b0, 8'h00, 1'b1, 4'h3, 12'hFF0, 8'h55, 12'hFF0);
    run_op(1'b0, 1'b0, 8'h60, 1'b1, 4'h3, 12'h100, 8'h02, 12'hF60);
    run_op(1'b0, 1'b0, 8'h10, 1'b0, 4'h9, 12'h100, 8'h81, 12'h010);
  endtask

  // A word with another opcode must start nothing.
  task automatic t_other_opcode();
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= {6'h11, 1'b1, 1'b0, 8'h20};
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      #1 chk({busy_o, mem_req_o.rd_en, mem_req_o.wr_en}, 3'h0, "foreign opcode");
    end
  endtask

  // Watchdog against a hang.
  initial begin
    #(2000 * 20);
    errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    errors            = 0;
    check_count       = 0;
    w_exp             = BYTE_RESET;
    rst_n_i           = 1'b0;
    instr_valid_i     = 1'b0;
    instr_i           = '0;
    ext_set_en_i      = 1'b0;
    bank_select_reg_i = 4'h0;
    index_base_i      = 12'h000;
    rd_data_i         = 8'h00;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk({busy_o, done_o, w_reg_o}, 10'h000, "reset state");
    t_dest_working();
    t_dest_file();
    t_indexed();
    t_other_opcode();
    test_done();
  end
endmodule
